/* File: design/rng_consts.vh */
// Contract
// - value read gives 16 random bits, upper zero
// - new values spaced at least 1.25 us
// - off bit clear keeps generator running
// - off bit set powers down oscillators
// - off bit set gates generator clock
// - ready flag shows a valid value
// - value read without value waits for one
// - ready flag stays low while disabled
// - host and internal consumer both served
`ifndef RNG_CONSTS_VH
`define RNG_CONSTS_VH
`define GEN_CONFIG_OFS 32'h0000_0000
`define GEN_STATUS_OFS 32'h0000_0004
`define RANDOM_OUT_OFS 32'h0000_0008
`define GEN_CONFIG_RST 32'h0000_0000
`define GENERATOR_OFF_BIT 2
`define READY_BIT 0
`define MIN_PERIOD_PS 1250000
`define CLK_PERIOD_PS 4000
`define MIN_PERIOD_CYC ((`MIN_PERIOD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HRESP_OKAY 1'b0
`endif

/* File: design/rng_bus_wrapper.v */
`timescale 1ns/1ps
`include "rng_consts.vh"
module rng_bus_wrapper #(
   parameter integer GAP_CYC = `MIN_PERIOD_CYC
) (
   input wire clk,
   input wire rstn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire noise_in,
   input wire int_req,
   output reg int_ack,
   output reg [15:0] int_data,
   output reg osc_powerdown,
   output reg gen_clk_en
);
   // last count value before a fresh word may be made
   localparam integer GAP_LIM_INT = GAP_CYC - 1;

   // two-stage synchroniser for the asynchronous entropy bit
   reg noise_s1_r;
   reg noise_s2_r;

   // register file and bus phase state
   reg [31:0] config_r;
   reg [31:0] config_nxt;
   reg wr_cfg_r;
   reg wr_cfg_nxt;
   reg pend_r;
   reg pend_nxt;

   // generator state
   reg [15:0] lfsr_r;
   reg [15:0] lfsr_nxt;
   reg [15:0] value_r;
   reg [15:0] value_nxt;
   reg valid_r;
   reg valid_nxt;
   reg [11:0] gap_r;
   reg [11:0] gap_nxt;

   // next values of the registered outputs
   reg [31:0] hrdata_nxt;
   reg hreadyout_nxt;
   reg hresp_nxt;
   reg int_ack_nxt;
   reg [15:0] int_data_nxt;
   reg osc_powerdown_nxt;
   reg gen_clk_en_nxt;

   // constants widened to 32 bits, then cut on purpose
   wire [31:0] gap_lim_w;
   wire [11:0] gap_lim;
   wire [31:0] config_ofs;
   wire [31:0] status_ofs;
   wire [31:0] value_ofs;
   wire [31:0] config_rst;

   // decoded request and generator handshakes
   wire gen_off;
   wire take;
   wire take_read;
   wire take_write;
   wire hit_config;
   wire hit_status;
   wire hit_value;
   wire feedback;
   wire ready_flag;
   wire host_take;
   wire int_take;
   wire consume;
   wire gap_done;

   assign gap_lim_w = GAP_LIM_INT;
   assign gap_lim = gap_lim_w[11:0];
   assign config_ofs = `GEN_CONFIG_OFS;
   assign status_ofs = `GEN_STATUS_OFS;
   assign value_ofs = `RANDOM_OUT_OFS;
   assign config_rst = `GEN_CONFIG_RST;

   assign gen_off = config_r[`GENERATOR_OFF_BIT];
   assign take = hsel && hready && htrans[1] && hreadyout;
   assign take_read = take && !hwrite;
   assign take_write = take && hwrite;
   // low byte decoded in full, so nearby offsets do not alias a register
   assign hit_config = haddr[7:0] == config_ofs[7:0];
   assign hit_status = haddr[7:0] == status_ofs[7:0];
   assign hit_value = haddr[7:0] == value_ofs[7:0];
   assign feedback = lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10] ^ noise_s2_r;
   assign ready_flag = valid_r && !gen_off;
   // host read wins over the internal consumer in the same cycle
   assign host_take = pend_r && ready_flag;
   assign int_take = int_req && ready_flag && !host_take && !int_ack;
   assign consume = host_take || int_take;
   assign gap_done = gap_r >= gap_lim;

   always @(posedge clk) begin
      if (!rstn) begin
         noise_s1_r <= 1'b0;
         noise_s2_r <= 1'b0;
      end else begin
         noise_s1_r <= noise_in;
         noise_s2_r <= noise_s1_r;
      end
   end

   // generator: LFSR, value and gap frozen while off, valid cleared, its clock being gated
   always @* begin
      lfsr_nxt = lfsr_r;
      value_nxt = value_r;
      valid_nxt = valid_r;
      gap_nxt = gap_r;
      if (gen_off) begin
         valid_nxt = 1'b0;
      end else begin
         lfsr_nxt = {lfsr_r[14:0], feedback};
         if (consume) begin
            valid_nxt = 1'b0;
            gap_nxt = 12'h000;
         end else if (!valid_r) begin
            if (gap_done) begin
               value_nxt = {lfsr_r[14:0], feedback};
               valid_nxt = 1'b1;
            end else begin
               gap_nxt = gap_r + 12'h001;
            end
         end
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         lfsr_r <= 16'h0001;
      end else begin
         lfsr_r <= lfsr_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         value_r <= 16'h0000;
      end else begin
         value_r <= value_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         valid_r <= 1'b0;
      end else begin
         valid_r <= valid_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         gap_r <= 12'h000;
      end else begin
         gap_r <= gap_nxt;
      end
   end

   // side outputs: power control and the internal consumer port
   always @* begin
      osc_powerdown_nxt = gen_off;
      gen_clk_en_nxt = !gen_off;
      int_ack_nxt = int_take;
      int_data_nxt = int_data;
      if (int_take) begin
         int_data_nxt = value_r;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         osc_powerdown <= 1'b0;
      end else begin
         osc_powerdown <= osc_powerdown_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         gen_clk_en <= 1'b1;
      end else begin
         gen_clk_en <= gen_clk_en_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         int_ack <= 1'b0;
      end else begin
         int_ack <= int_ack_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         int_data <= 16'h0000;
      end else begin
         int_data <= int_data_nxt;
      end
   end

   // config write: address phase flagged, data taken one cycle later
   always @* begin
      config_nxt = config_r;
      wr_cfg_nxt = 1'b0;
      if (wr_cfg_r) begin
         config_nxt = hwdata;
      end
      if (take_write && hit_config) begin
         wr_cfg_nxt = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         config_r <= config_rst;
      end else begin
         config_r <= config_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         wr_cfg_r <= 1'b0;
      end else begin
         wr_cfg_r <= wr_cfg_nxt;
      end
   end

   // reads: value read stalls until a word is ready, never errors
   always @* begin
      pend_nxt = pend_r;
      hrdata_nxt = hrdata;
      hreadyout_nxt = hreadyout;
      hresp_nxt = `HRESP_OKAY;
      if (pend_r) begin
         if (host_take) begin
            hrdata_nxt = {16'h0000, value_r};
            hreadyout_nxt = 1'b1;
            pend_nxt = 1'b0;
         end
      end else if (take_write) begin
         hrdata_nxt = 32'h0000_0000;
      end else if (take_read) begin
         if (hit_value) begin
            pend_nxt = 1'b1;
            hreadyout_nxt = 1'b0;
         end else if (hit_config) begin
            hrdata_nxt = config_r;
         end else if (hit_status) begin
            hrdata_nxt = {31'h0000_0000, ready_flag};
         end else begin
            hrdata_nxt = 32'h0000_0000;
         end
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         hrdata <= 32'h0000_0000;
      end else begin
         hrdata <= hrdata_nxt;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= hreadyout_nxt;
      end
   end

   // response is tied to okay, but kept registered like every output
   always @(posedge clk) begin
      if (!rstn) begin
         hresp <= `HRESP_OKAY;
      end else begin
         hresp <= hresp_nxt;
      end
   end

   // note: a stalled value read holds the bus through any disable
   // period; no write is taken while stalled, so only reset releases it
endmodule

/* File: sim/rng_bus_wrapper_assertions.sv */
`timescale 1ns/1ps
module rng_chk(input wire clk,rstn,hsel,hwrite,hready,hreadyout,hresp,int_ack,osc_powerdown,
   gen_clk_en,input wire [31:0] haddr,hrdata,input wire [1:0] htrans);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
wire rd=hsel&&hready&&htrans[1]&&hreadyout&&!hwrite;
property p_ok; hresp==1'b0; endproperty
a_ok: assert property(p_ok) else $error("error response seen");
property p_pd; osc_powerdown!=gen_clk_en; endproperty
a_pd: assert property(p_pd) else $error("power-down and clock gate disagree");
property p_hi; $rose(hreadyout) |-> hrdata[31:16]==16'h0000; endproperty
a_hi: assert property(p_hi) else $error("upper value bits not zero");
property p_st; rd&&haddr==32'h0000_0008 |=> !hreadyout; endproperty
a_st: assert property(p_st) else $error("value read not stalled");
property p_wt; $fell(hreadyout) |-> ##[1:40] (hreadyout||osc_powerdown); endproperty
a_wt: assert property(p_wt) else $error("stalled read never completed");
property p_gap; int_ack |=> !int_ack[*3]; endproperty
a_gap: assert property(p_gap) else $error("values produced too close");
property p_off; osc_powerdown&&$past(osc_powerdown,2) |-> !int_ack; endproperty
a_off: assert property(p_off) else $error("value delivered while off");
property p_rdy; rd&&haddr==32'h0000_0004&&osc_powerdown&&$past(osc_powerdown)
   |=> hrdata[0]==1'b0; endproperty
a_rdy: assert property(p_rdy) else $error("ready set while off");
endmodule
bind rng_bus_wrapper rng_chk i_rng_chk(.*);

/* File: sim/ahb_host.sv */
`timescale 1ns/1ps
module ahb_host(input wire clk,hreadyout,input wire [31:0] hrdata,output logic hsel,hwrite,
   output logic [31:0] haddr,hwdata,output logic [1:0] htrans,output logic [2:0] hsize);
initial {hsel,hwrite,haddr,hwdata,htrans}=0;
assign hsize=3'h2;
task xfer(input [31:0] a,input w,input [31:0] d,output [31:0] r);
   @(negedge clk);
   {hsel,htrans,haddr,hwrite}={1'b1,2'h2,a,w};
   @(negedge clk);
   {hsel,htrans}=0;
   hwdata=d&32'h0000_0004;
   while (!hreadyout) @(negedge clk);
   r=hrdata;
   @(posedge clk);
endtask
endmodule

/* File: sim/rng_bus_wrapper_tb.sv */
`timescale 1ns/1ps
module rng_bus_wrapper_tb;
logic clk=0,rstn=0,noise_in=0,int_req=0,hsel,hwrite,hreadyout,hresp,int_ack,osc_powerdown;
logic gen_clk_en;
logic [31:0] haddr,hwdata,hrdata,r,q[$];
logic [1:0] htrans;
logic [2:0] hsize;
logic [15:0] int_data;
wire hready=hreadyout;
int err_total=0,total_checks=0;
int unsigned s=27;
rng_bus_wrapper #(.GAP_CYC(4)) i_rng_bus_wrapper(.*);
ahb_host i_ahb_host(.*);
function int unsigned xs(int unsigned x);
   x^=x<<13; x^=x>>17; return x^(x<<5);
endfunction
initial forever #2 clk=~clk;
always @(negedge clk) begin
   s=xs(s); {noise_in,int_req}=s[1:0];
end
task chk(input string n,input logic [31:0] v,e);
   total_checks++;
   if (v!==e) begin
      err_total++; $display("FAIL %s exp %h got %h",n,e,v);
   end
endtask
task tally_and_finish;
   $display("checks %0d errors %0d",total_checks,err_total);
   if (err_total==0&&total_checks>0) $display("ALL CHECKS OK");
   else $display("CHECKS NOT OK");
   $finish;
endtask
initial begin
   repeat (10) @(negedge clk);
   rstn=1;
   chk("rst",{hreadyout,hresp,osc_powerdown,gen_clk_en},4'b1001);
   i_ahb_host.xfer(0,0,0,r); chk("cfg",r,0);
   for (int i=0; i<6; i++) begin
      i_ahb_host.xfer(8,0,0,r); chk("hi",r>>16,0);
      if (i>0) chk("new",r!==q[$],1);
      q.push_back(r);
   end
   i_ahb_host.xfer(4,1,-1,r); i_ahb_host.xfer(16,0,0,r); chk("map",r,0);
   i_ahb_host.xfer(0,1,4,r); i_ahb_host.xfer(0,0,0,r); chk("cfg",r,4);
   repeat (20) @(negedge clk);
   i_ahb_host.xfer(4,0,0,r); chk("rdy",r,0);
   chk("off",{osc_powerdown,gen_clk_en},2);
   i_ahb_host.xfer(0,1,0,r); i_ahb_host.xfer(8,0,0,r); chk("hi",r>>16,0);
   tally_and_finish;
end
initial begin
   #20000; err_total++; tally_and_finish;
end
endmodule
